//--- rtl/lgsm_map.svh
// lgsm_map.svh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the pin mux design file
`ifndef LGSM_MAP_SVH
`define LGSM_MAP_SVH

// ==========================================================================
// clock and timing
`define LGSM_CLK_PERIOD_NS 25
`define LGSM_STRAP_SETTLE_NS 200
// least time, rounded up to whole cycles
`define LGSM_STRAP_SETTLE_CYC ((`LGSM_STRAP_SETTLE_NS + `LGSM_CLK_PERIOD_NS - 1) / `LGSM_CLK_PERIOD_NS)

// ==========================================================================
// register byte offsets
`define LGSM_OFS_LIGHT_CONFIG 5'h00
`define LGSM_OFS_GPIO_CONFIG 5'h04
`define LGSM_OFS_GPIO_DATA_DIR 5'h08
`define LGSM_OFS_STRAP_STATUS 5'h0c

// ==========================================================================
// light_config_reg fields
`define LGSM_LCFG_EN_LSB 0
`define LGSM_LCFG_FUNC_LSB 8
`define LGSM_LCFG_EN_RST 2'h3
`define LGSM_LCFG_FUNC_RST 3'h0
// function codes with this bit set use the open-drain/open-source driver
`define LGSM_FUNC_OD_BIT 2

// ==========================================================================
// gpio config and data/direction fields
`define LGSM_GCFG_OD_LSB 0
`define LGSM_GDD_DATA_LSB 0
`define LGSM_GDD_DIR_LSB 8
`define LGSM_GCFG_OD_RST 2'h0
`define LGSM_GDD_DATA_RST 2'h0
`define LGSM_GDD_DIR_RST 2'h0

// ==========================================================================
// strap status fields
`define LGSM_STS_E2P_BIT 0
`define LGSM_STS_P1PHY_BIT 1
`define LGSM_STS_VALID_BIT 2

`endif

//--- rtl/lgsm_pkg.sv
// lgsm_pkg.sv: types shared by the status-light / general pin / strap mux
// assumes: nothing beyond the map header
package lgsm_pkg;

    // ======================================================================
    // strap capture sequence
    typedef enum logic [3:0] {
        lgsm_st_hold = 4'b0001,
        lgsm_st_settle = 4'b0010,
        lgsm_st_sample = 4'b0100,
        lgsm_st_run = 4'b1000
    } lgsm_state_type;

    // ======================================================================
    // all state of the top module
    typedef struct packed {
        lgsm_state_type st;
        logic [3:0] cnt;
        logic [1:0] led_en;
        logic [2:0] func;
        logic [1:0] gpio_od;
        logic [1:0] gpio_dout;
        logic [1:0] gpio_dir;
        logic e2p_strap;
        logic p1phy_strap;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] pin_out;
        logic [1:0] pin_oe;
    } lgsm_regs_type;

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
    } lgsm_sync_type;

endpackage

//--- rtl/lgsm_sync2.sv
// lgsm_sync2.sv: two-flip-flop synchroniser for three pin levels
// assumes: ref_clk domain; inputs arrive asynchronously from board pins
`timescale 1ns/10ps
module lgsm_sync2 (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [2:0] async_in,
    output logic [2:0] sync_out
);

    // ======================================================================
    // state
    lgsm_pkg::lgsm_sync_type r_q;
    lgsm_pkg::lgsm_sync_type r_d;

    always_comb begin
        r_d.meta = async_in;
        r_d.sync = r_q.meta;
    end

    // reset value 1: strap and reset pins carry pull-ups
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r_q <= {3'h7, 3'h7};
        end else begin
            r_q <= r_d;
        end
    end

    assign sync_out = r_q.sync;

endmodule

//--- rtl/lgsm_pin_cell.sv
// lgsm_pin_cell.sv: driver choice for one shared pin
// assumes: all inputs are ref_clk-domain levels; caller registers the results
`timescale 1ns/10ps
module lgsm_pin_cell (
    input wire logic drive_ok,
    input wire logic led_mode,
    input wire logic led_on,
    input wire logic led_od,
    input wire logic led_strap,
    input wire logic gpio_od,
    input wire logic gpio_dir,
    input wire logic gpio_dout,
    output logic pin_out,
    output logic pin_oe
);

    // ======================================================================
    // driver mux
    always_comb begin
        pin_out = 1'b0;
        pin_oe = 1'b0;
        if (!drive_ok) begin
            // pins float so only board pulls set the strap
            pin_out = 1'b0;
            pin_oe = 1'b0;
        end else if (led_mode) begin
            if (led_od) begin
                // strap high: sinks when lit; strap low: sources when lit
                pin_out = ~led_strap;
                pin_oe = led_on;
            end else begin
                pin_out = led_on;
                pin_oe = 1'b1;
            end
        end else if (gpio_dir) begin
            if (gpio_od) begin
                pin_out = 1'b0;
                pin_oe = ~gpio_dout;
            end else begin
                pin_out = gpio_dout;
                pin_oe = 1'b1;
            end
        end
    end

endmodule

//--- rtl/lgsm_pin_mux.sv
// lgsm_pin_mux.sv: two shared pins as status light, general pin or reset strap
// assumes: ref_clk at 40 MHz, sys_rst is the power-on reset, light activity
// comes from logic on ref_clk, registers reached over Avalon-MM
//
// Contract
// - pin two drives its light when its enable bit is set, else it is a general pin.
// - pin one drives its light when its enable bit is set, else it is a general pin.
// - in light mode the three-bit function field picks push-pull or open-drain/open-source.
// - open-drain light on pin two takes its polarity from the latched eeprom size strap.
// - open-drain light on pin one takes its polarity from the latched port-one phy strap.
// - as a general pin each pin is a push-pull output, open-drain output or input by register.
// - the eeprom size strap is a hard strap with no software override.
// - a low eeprom size strap selects the 1K to 16K bit range.
// - a high eeprom size strap selects the 32K to 512K bit range.
// - the latched port-one phy strap feeds mode selection of ports zero and one.
// - straps are captured after power-on reset and after each external reset release.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`include "lgsm_map.svh"
module lgsm_pin_mux (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ext_rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [1:0] light_activity,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    output logic eeprom_large_range,
    output logic port_one_internal_phy_strap,
    output logic strap_valid
);

    // ======================================================================
    // pin synchronisers: index 0 pin one, 1 pin two, 2 external reset
    logic [2:0] pins_sync;

    lgsm_sync2 u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in({ext_rst_n, pin_in}),
        .sync_out(pins_sync)
    );

    logic int_rst;
    // internal reset covers power-on and external reset
    assign int_rst = sys_rst | ~pins_sync[2];

    // ======================================================================
    // state
    lgsm_pkg::lgsm_regs_type r_q;
    lgsm_pkg::lgsm_regs_type r_d;

    logic drive_ok;
    logic [1:0] light_mode;
    logic [1:0] light_strap;
    logic [1:0] cell_out;
    logic [1:0] cell_oe;
    logic req;
    logic [31:0] rd_mux;
    logic [31:0] wmask;

    assign drive_ok = (r_q.st == lgsm_pkg::lgsm_st_run);
    assign light_mode = r_q.led_en;
    // pin one polarity from port-one phy strap, pin two from eeprom strap
    assign light_strap = {r_q.e2p_strap, r_q.p1phy_strap};
    assign req = avs_read | avs_write;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // ======================================================================
    // per-pin driver choice
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            lgsm_pin_cell u_cell (
                .drive_ok(drive_ok),
                .led_mode(light_mode[gi]),
                .led_on(light_activity[gi]),
                .led_od(r_q.func[`LGSM_FUNC_OD_BIT]),
                .led_strap(light_strap[gi]),
                .gpio_od(r_q.gpio_od[gi]),
                .gpio_dir(r_q.gpio_dir[gi]),
                .gpio_dout(r_q.gpio_dout[gi]),
                .pin_out(cell_out[gi]),
                .pin_oe(cell_oe[gi])
            );
        end
    endgenerate

    // ======================================================================
    // register read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            `LGSM_OFS_LIGHT_CONFIG: begin
                rd_mux[`LGSM_LCFG_EN_LSB +: 2] = r_q.led_en;
                rd_mux[`LGSM_LCFG_FUNC_LSB +: 3] = r_q.func;
            end
            `LGSM_OFS_GPIO_CONFIG: begin
                rd_mux[`LGSM_GCFG_OD_LSB +: 2] = r_q.gpio_od;
            end
            `LGSM_OFS_GPIO_DATA_DIR: begin
                // input pins read their level, output pins their data bit
                rd_mux[`LGSM_GDD_DATA_LSB +: 2] = (r_q.gpio_dir & r_q.gpio_dout) | (~r_q.gpio_dir & pins_sync[1:0]);
                rd_mux[`LGSM_GDD_DIR_LSB +: 2] = r_q.gpio_dir;
            end
            `LGSM_OFS_STRAP_STATUS: begin
                rd_mux[`LGSM_STS_E2P_BIT] = r_q.e2p_strap;
                rd_mux[`LGSM_STS_P1PHY_BIT] = r_q.p1phy_strap;
                rd_mux[`LGSM_STS_VALID_BIT] = drive_ok;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // ======================================================================
    // next state
    always_comb begin
        r_d = r_q;
        r_d.ack = req & ~r_q.ack;
        if (req & ~r_q.ack) begin
            r_d.rdata = avs_read ? rd_mux : 32'h0000_0000;
        end

        // strap capture sequence; straps are read-only, no write reaches them
        unique case (r_q.st)
            lgsm_pkg::lgsm_st_hold: begin
                r_d.st = lgsm_pkg::lgsm_st_settle;
                r_d.cnt = 4'h0;
            end
            lgsm_pkg::lgsm_st_settle: begin
                r_d.cnt = r_q.cnt + 4'h1;
                if (r_q.cnt == 4'(`LGSM_STRAP_SETTLE_CYC - 1)) begin
                    r_d.st = lgsm_pkg::lgsm_st_sample;
                end
            end
            lgsm_pkg::lgsm_st_sample: begin
                r_d.e2p_strap = pins_sync[1];
                r_d.p1phy_strap = pins_sync[0];
                r_d.st = lgsm_pkg::lgsm_st_run;
            end
            lgsm_pkg::lgsm_st_run: begin
                r_d.st = lgsm_pkg::lgsm_st_run;
            end
            default: begin
                r_d.st = lgsm_pkg::lgsm_st_hold;
            end
        endcase

        // register writes take effect one edge after the edge that ends waitrequest
        if (avs_write & r_q.ack) begin
            unique case (avs_address)
                `LGSM_OFS_LIGHT_CONFIG: begin
                    if (avs_byteenable[0]) begin
                        r_d.led_en = avs_writedata[`LGSM_LCFG_EN_LSB +: 2];
                    end
                    if (avs_byteenable[1]) begin
                        r_d.func = avs_writedata[`LGSM_LCFG_FUNC_LSB +: 3];
                    end
                end
                `LGSM_OFS_GPIO_CONFIG: begin
                    if (wmask[`LGSM_GCFG_OD_LSB]) begin
                        r_d.gpio_od = avs_writedata[`LGSM_GCFG_OD_LSB +: 2];
                    end
                end
                `LGSM_OFS_GPIO_DATA_DIR: begin
                    if (wmask[`LGSM_GDD_DATA_LSB]) begin
                        r_d.gpio_dout = avs_writedata[`LGSM_GDD_DATA_LSB +: 2];
                    end
                    if (wmask[`LGSM_GDD_DIR_LSB]) begin
                        r_d.gpio_dir = avs_writedata[`LGSM_GDD_DIR_LSB +: 2];
                    end
                end
                default: begin
                    r_d.rdata = r_d.rdata;
                end
            endcase
        end

        r_d.pin_out = cell_out;
        r_d.pin_oe = cell_oe;
    end

    // ======================================================================
    // registers
    always_ff @(posedge ref_clk) begin
        if (int_rst) begin
            r_q.st <= lgsm_pkg::lgsm_st_hold;
            r_q.cnt <= 4'h0;
            r_q.led_en <= `LGSM_LCFG_EN_RST;
            r_q.func <= `LGSM_LCFG_FUNC_RST;
            r_q.gpio_od <= `LGSM_GCFG_OD_RST;
            r_q.gpio_dout <= `LGSM_GDD_DATA_RST;
            r_q.gpio_dir <= `LGSM_GDD_DIR_RST;
            r_q.e2p_strap <= 1'b1;
            r_q.p1phy_strap <= 1'b1;
            r_q.ack <= 1'b0;
            r_q.rdata <= 32'h0000_0000;
            r_q.pin_out <= 2'h0;
            r_q.pin_oe <= 2'h0;
        end else begin
            r_q <= r_d;
        end
    end

    // ======================================================================
    // outputs
    assign avs_waitrequest = req & ~r_q.ack;
    assign avs_readdata = r_q.rdata;
    assign pin_out = r_q.pin_out;
    assign pin_oe = r_q.pin_oe;
    assign eeprom_large_range = r_q.e2p_strap;
    assign port_one_internal_phy_strap = r_q.p1phy_strap;
    assign strap_valid = drive_ok;

endmodule

//--- bench/lgsm_board.sv
// lgsm_board.sv: board side of the two shared pins and their strap resistors
// assumes: pin_oe high means the mux drives the pin
`timescale 1ns/10ps
module lgsm_board (
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] strap_pull,
    output logic [1:0] pin_in
);
    // =====================================================================
    // an undriven pin rests at its strap resistor level
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : strap_pull[i];
        end
    end
endmodule

//--- bench/lgsm_pin_mux_sva.sv
// lgsm_pin_mux_sva.sv: port checks for the status-light / general pin / strap mux
// assumes: bound to lgsm_pin_mux, single ref_clk domain
`timescale 1ns/10ps
module lgsm_pin_mux_chk (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ext_rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] pin_in,
    input wire logic [1:0] pin_oe,
    input wire logic eeprom_large_range,
    input wire logic port_one_internal_phy_strap,
    input wire logic strap_valid
);
    // =====================================================================
    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_settle;
        !strap_valid [*8];
    endsequence
    a_drive_off: assert property (!strap_valid |-> pin_oe == 2'h0) else $error("pin driven early");
    a_first_capture: assert property ($fell(sys_rst) |-> s_settle ##[1:5] strap_valid) else $error("capture late");
    a_ext_hold: assert property (!ext_rst_n [*4] |-> !strap_valid) else $error("ext reset ignored");
    a_ext_capture: assert property ($rose(ext_rst_n) && !strap_valid |-> ##[9:16] strap_valid) else $error("no recapture");
    a_strap_source: assert property ($rose(strap_valid) |->
        {eeprom_large_range, port_one_internal_phy_strap} == pin_in) else $error("strap not from pins");
    a_strap_fixed: assert property (strap_valid && $past(strap_valid) |->
        $stable({eeprom_large_range, port_one_internal_phy_strap})) else $error("strap changed");
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait state");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
    a_status_bits: assert property (avs_read && !avs_waitrequest && avs_address == 5'h0c && $stable(strap_valid) |->
        avs_readdata[2:0] == {strap_valid, port_one_internal_phy_strap, eeprom_large_range})
        else $error("status mismatch");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && !(avs_address inside {5'h00, 5'h04, 5'h08, 5'h0c})
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
endmodule

//--- bench/led_gpio_strap_pin_mux_tb.sv
// led_gpio_strap_pin_mux_tb.sv: bus-driven scenarios for the pin mux
// assumes: design, board model and checker compiled before this file
`timescale 1ns/10ps
module led_gpio_strap_pin_mux_tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ext_rst_n = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] light_activity = 2'h0;
    logic [1:0] strap_pull = 2'h1;
    logic [1:0] pin_in;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic eeprom_large_range;
    logic port_one_internal_phy_strap;
    logic strap_valid;
    logic [31:0] rdat;
    int failures = 0;
    int comparisons = 0;

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    lgsm_pin_mux u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ext_rst_n(ext_rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .light_activity(light_activity),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .eeprom_large_range(eeprom_large_range),
        .port_one_internal_phy_strap(port_one_internal_phy_strap), .strap_valid(strap_valid));
    lgsm_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .strap_pull(strap_pull), .pin_in(pin_in));

    // =====================================================================
    // helpers
    task automatic stop_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) begin
            failures++;
            stop_test();
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask

    // pin results show one edge after their cause
    task automatic pins(input logic [3:0] exp);
        repeat (2) @(posedge ref_clk);
        check({28'h0, pin_oe, pin_out}, {28'h0, exp});
    endtask

    task automatic wait_valid;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (strap_valid !== 1'b1 && n < 60);
        if (n >= 60) begin
            failures++;
            stop_test();
        end
    endtask

    // =====================================================================
    // scenarios
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wait_valid();
        check({30'h0, eeprom_large_range, port_one_internal_phy_strap}, 32'h1);
        rd(5'h0c, 32'h6);
        bus(1'b1, 5'h0c, 32'hffff_ffff);
        rd(5'h0c, 32'h6);
        rd(5'h00, 32'h3);
        rd(5'h04, 32'h0);
        // light pins drive the push-pull level of an idle light
        rd(5'h08, 32'h0);
        rd(5'h10, 32'h0);
        avs_byteenable <= 4'h2;
        bus(1'b1, 5'h00, 32'h0000_0500);
        avs_byteenable <= 4'hf;
        rd(5'h00, 32'h0000_0503);
        light_activity <= 2'h1;
        for (int f = 0; f < 8; f++) begin
            bus(1'b1, 5'h00, {21'h0, f[2:0], 8'h03});
            pins(f[2] ? 4'h6 : 4'hd);
        end
        light_activity <= 2'h2;
        pins(4'ha);
        bus(1'b1, 5'h00, 32'h3);
        pins(4'he);
        bus(1'b1, 5'h00, 32'h0);
        bus(1'b1, 5'h08, 32'h0000_0301);
        pins(4'hd);
        bus(1'b1, 5'h04, 32'h3);
        pins(4'h8);
        bus(1'b1, 5'h08, 32'h0);
        repeat (4) @(posedge ref_clk);
        check({30'h0, pin_oe}, 32'h0);
        rd(5'h08, 32'h1);
        strap_pull <= 2'h2;
        ext_rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check({30'h0, pin_oe}, 32'h0);
        ext_rst_n <= 1'b1;
        wait_valid();
        check({30'h0, eeprom_large_range, port_one_internal_phy_strap}, 32'h2);
        rd(5'h0c, 32'h5);
        rd(5'h00, 32'h3);
        stop_test();
    end
endmodule

bind lgsm_pin_mux lgsm_pin_mux_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .ext_rst_n(ext_rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_oe(pin_oe), .eeprom_large_range(eeprom_large_range),
    .port_one_internal_phy_strap(port_one_internal_phy_strap), .strap_valid(strap_valid));
